//--- rtl/sfhp_pkg.sv
/*
 * Shared constants and types for the synchronous FIFO host port.
 * Assumes one system clock at SYS_CLK_HZ; the link divider count is derived from it and LINK_PERIOD_NS.
 */
package sfhp_pkg;

    localparam int DATA_W           = 8;
    localparam int BUF_AW           = 4;
    localparam int BUF_DEPTH        = 16;
    localparam int CNT_W            = BUF_AW + 1;

    localparam int SYS_CLK_HZ       = 10_000_000;
    localparam int IFCLK_NOMINAL_HZ = 60_000_000;
    localparam int LINK_PERIOD_NS   = 800;
    localparam int SYS_PERIOD_NS    = 1_000_000_000 / SYS_CLK_HZ;
    localparam int LINK_HALF_CYCLES = (LINK_PERIOD_NS / 2) / SYS_PERIOD_NS;
    localparam int DIV_W            = 3;

    localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(LINK_HALF_CYCLES - 1);
    localparam logic [DIV_W-1:0]  DIV_RST   = 3'h0;
    localparam logic [CNT_W-1:0]  CNT_FULL  = CNT_W'(BUF_DEPTH);
    localparam logic [CNT_W-1:0]  CNT_RST   = 5'h00;
    localparam logic [BUF_AW-1:0] PTR_RST   = 4'h0;
    localparam logic [DATA_W-1:0] DATA_RST  = 8'h00;

    typedef logic [BUF_AW-1:0] sfhp_ptr_t;

    typedef enum logic [1:0]
    {
        SFHP_OFF  = 2'b01,
        SFHP_SYNC = 2'b10
    } sfhp_mode_e;

    function automatic sfhp_ptr_t sfhp_ptr_inc(input sfhp_ptr_t p);
        sfhp_ptr_inc = p + 4'h1;
    endfunction

    function automatic logic [CNT_W-1:0] sfhp_cnt_step(input logic [CNT_W-1:0] c,
                                                       input logic            inc,
                                                       input logic            dec);
        sfhp_cnt_step = c + CNT_W'(inc) - CNT_W'(dec);
    endfunction

endpackage

//--- rtl/sfhp_mem_if.sv
/*
 * Bundle between the port controller and one byte buffer memory.
 * Assumes the memory answers a read address one clock later.
 */
`timescale 1ns/100ps

interface sfhp_mem_if;
    import sfhp_pkg::*;

    logic              we;
    logic [BUF_AW-1:0] waddr;
    logic [DATA_W-1:0] wdata;
    logic [BUF_AW-1:0] raddr;
    logic [DATA_W-1:0] rdata;

    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

//--- rtl/sfhp_mem.sv
/*
 * Small byte buffer memory, one write port and one registered read port.
 * Assumes a single clock shared with the controller.
 */
`timescale 1ns/100ps

module sfhp_mem
    import sfhp_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset,
    sfhp_mem_if.mem   bus
);

    logic [DATA_W-1:0] store [BUF_DEPTH];
    logic [DATA_W-1:0] next_rdata;
    logic [DATA_W-1:0] rdata_q;

    always_comb
    begin
        next_rdata = store[bus.raddr];
    end

    always_ff @(posedge clk_sys)
    begin
        if (bus.we)
        begin
            store[bus.waddr] <= bus.wdata;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            rdata_q <= DATA_RST;
        end
        else
        begin
            rdata_q <= next_rdata;
        end
    end

    assign bus.rdata = rdata_q;

endmodule

//--- rtl/sfhp_port.sv
/*
 * Single-channel synchronous parallel FIFO port on channel A.
 * Assumes the USB engine side runs on clk_sys; strobes, output enable, data
 * and the send-now pin come from outside and are synchronised here.
 */
`timescale 1ns/100ps

// Contract
// - Synchronous FIFO mode exists on channel A only and disables channel B while active.
// - The mode is entered only with the FIFO personality set and a later bit-mode request.
// - Transfers happen on rising edges of the interface clock the device drives out.
// - The interface clock is generated and driven continuously while the mode is active.
// - The data bus is an input and is driven only while output enable is low.
// - Data-available stays high with no receive byte and low signals readable data.
// - One receive byte moves on every clock edge with data-available and read strobe low.
// - When the read strobe falls the current receive byte is on the bus.
// - With read strobe low the next byte is fetched each clock until it rises.
// - Space-available stays high when the transmit buffer is full and low permits writing.
// - One byte is captured on every clock edge with space-available and write strobe low.
// - With write strobe low a further byte is stored each clock until it rises.
// - When suspended with remote wakeup enabled a low send-now pulse requests resume.
// - In normal operation a low send-now pulse flushes pending transmit data at next bulk-in.
module sfhp_port
    import sfhp_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              cfg_fifo_personality,
    input  wire logic              bitmode_sync_req,
    input  wire logic              bitmode_exit_req,
    input  wire logic              usb_suspended,
    input  wire logic              remote_wakeup_en,
    output logic                   mode_active,
    output logic                   channel_b_disabled,
    output logic                   interface_clock_out,
    output logic                   rx_data_avail_n,
    output logic                   tx_space_avail_n,
    input  wire logic              rd_strobe_n,
    input  wire logic              wr_strobe_n,
    input  wire logic              output_enable_n,
    input  wire logic [DATA_W-1:0] port_a_data_in,
    output logic      [DATA_W-1:0] port_a_data_out,
    output logic                   port_a_data_oe_n,
    input  wire logic              send_now_wakeup_n,
    output logic                   power_enable_n,
    output logic                   resume_request,
    input  wire logic              bulk_in_req,
    output logic                   tx_flush,
    input  wire logic              rx_in_valid,
    input  wire logic [DATA_W-1:0] rx_in_data,
    output logic                   rx_in_ready,
    output logic                   tx_out_valid,
    output logic      [DATA_W-1:0] tx_out_data,
    input  wire logic              tx_out_ready
);

    sfhp_mode_e        mode;
    sfhp_mode_e        next_mode;

    logic [DIV_W-1:0]  div_cnt;
    logic [DIV_W-1:0]  next_div_cnt;
    logic              ifclk;
    logic              next_ifclk;
    logic              rise_tick;

    logic [3:0]        pin_s1;
    logic [3:0]        pin_s2;
    logic [DATA_W-1:0] din_s1;
    logic [DATA_W-1:0] din_s2;
    logic              send_now_wakeup_n_q;
    logic              rd_n;
    logic              wr_n;
    logic              oe_n;
    logic              send_now_wakeup_n_n;
    logic              send_now_wakeup_n_fall;

    sfhp_ptr_t         rx_wptr;
    sfhp_ptr_t         rx_rptr;
    sfhp_ptr_t         tx_wptr;
    sfhp_ptr_t         tx_rptr;
    logic [CNT_W-1:0]  rx_cnt;
    logic [CNT_W-1:0]  tx_cnt;
    sfhp_ptr_t         next_rx_wptr;
    sfhp_ptr_t         next_rx_rptr;
    sfhp_ptr_t         next_tx_wptr;
    sfhp_ptr_t         next_tx_rptr;
    logic [CNT_W-1:0]  next_rx_cnt;
    logic [CNT_W-1:0]  next_tx_cnt;
    logic              tx_settled;
    logic              next_tx_settled;

    logic              rx_push;
    logic              rx_pop;
    logic              tx_push;
    logic              tx_pop;

    logic              rxf_n;
    logic              txe_n;
    logic              data_oe_n;
    logic              pwr_n;
    logic              resume_q;
    logic              flush_pending;
    logic              flush_q;
    logic              next_rxf_n;
    logic              next_txe_n;
    logic              next_data_oe_n;
    logic              next_resume;
    logic              next_flush_pending;
    logic              next_flush;

    sfhp_mem_if        rx_bus ();
    sfhp_mem_if        tx_bus ();

    sfhp_mem u_rx_mem
    (
        .clk_sys (clk_sys),
        .reset   (reset),
        .bus     (rx_bus)
    );

    sfhp_mem u_tx_mem
    (
        .clk_sys (clk_sys),
        .reset   (reset),
        .bus     (tx_bus)
    );

    // Mode entry and exit
    always_comb
    begin
        next_mode = mode;
        unique case (mode)
            SFHP_OFF:
            begin
                if (cfg_fifo_personality && bitmode_sync_req)
                begin
                    next_mode = SFHP_SYNC;
                end
            end
            SFHP_SYNC:
            begin
                if (bitmode_exit_req || !cfg_fifo_personality)
                begin
                    next_mode = SFHP_OFF;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            mode <= SFHP_OFF;
        end
        else
        begin
            mode <= next_mode;
        end
    end

    assign mode_active        = (mode == SFHP_SYNC);
    assign channel_b_disabled = mode_active;

    // Interface clock divider, runs only in the mode
    always_comb
    begin
        next_div_cnt = DIV_RST;
        next_ifclk   = 1'b0;
        if (mode_active)
        begin
            next_div_cnt = div_cnt + 3'h1;
            next_ifclk   = ifclk;
            if (div_cnt == DIV_LAST)
            begin
                next_div_cnt = DIV_RST;
                next_ifclk   = !ifclk;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            div_cnt <= DIV_RST;
            ifclk   <= 1'b0;
        end
        else
        begin
            div_cnt <= next_div_cnt;
            ifclk   <= next_ifclk;
        end
    end

    assign interface_clock_out = ifclk;
    assign rise_tick           = mode_active && !ifclk && (div_cnt == DIV_LAST);

    // Pin synchronisers
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            pin_s1 <= 4'hf;
            pin_s2 <= 4'hf;
            din_s1 <= DATA_RST;
            din_s2 <= DATA_RST;
            send_now_wakeup_n_q <= 1'b1;
        end
        else
        begin
            pin_s1 <= {send_now_wakeup_n, output_enable_n, wr_strobe_n, rd_strobe_n};
            pin_s2 <= pin_s1;
            din_s1 <= port_a_data_in;
            din_s2 <= din_s1;
            send_now_wakeup_n_q <= pin_s2[3];
        end
    end

    assign rd_n      = pin_s2[0];
    assign wr_n      = pin_s2[1];
    assign oe_n      = pin_s2[2];
    assign send_now_wakeup_n_n    = pin_s2[3];
    assign send_now_wakeup_n_fall = send_now_wakeup_n_q && !send_now_wakeup_n_n;

    // Pin-side transfers on the interface clock rising edge, engine-side transfers on any clk_sys cycle
    assign rx_pop  = rise_tick && !rxf_n && !rd_n;
    assign tx_push = rise_tick && !txe_n && !wr_n;
    assign rx_push = rx_in_valid && rx_in_ready;
    assign tx_pop  = tx_out_valid && tx_out_ready;

    always_comb
    begin
        next_rx_wptr    = rx_push ? sfhp_ptr_inc(rx_wptr) : rx_wptr;
        next_rx_rptr    = rx_pop ? sfhp_ptr_inc(rx_rptr) : rx_rptr;
        next_tx_wptr    = tx_push ? sfhp_ptr_inc(tx_wptr) : tx_wptr;
        next_tx_rptr    = tx_pop ? sfhp_ptr_inc(tx_rptr) : tx_rptr;
        next_rx_cnt     = sfhp_cnt_step(rx_cnt, rx_push, rx_pop);
        next_tx_cnt     = sfhp_cnt_step(tx_cnt, tx_push, tx_pop);
        next_tx_settled = !(tx_push || tx_pop);
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            rx_wptr    <= PTR_RST;
            rx_rptr    <= PTR_RST;
            tx_wptr    <= PTR_RST;
            tx_rptr    <= PTR_RST;
            rx_cnt     <= CNT_RST;
            tx_cnt     <= CNT_RST;
            tx_settled <= 1'b0;
        end
        else
        begin
            rx_wptr    <= next_rx_wptr;
            rx_rptr    <= next_rx_rptr;
            tx_wptr    <= next_tx_wptr;
            tx_rptr    <= next_tx_rptr;
            rx_cnt     <= next_rx_cnt;
            tx_cnt     <= next_tx_cnt;
            tx_settled <= next_tx_settled;
        end
    end

    assign rx_bus.we    = rx_push;
    assign rx_bus.waddr = rx_wptr;
    assign rx_bus.wdata = rx_in_data;
    assign rx_bus.raddr = next_rx_rptr;
    assign tx_bus.we    = tx_push;
    assign tx_bus.waddr = tx_wptr;
    assign tx_bus.wdata = din_s2;
    assign tx_bus.raddr = next_tx_rptr;

    assign rx_in_ready  = (rx_cnt != CNT_FULL);
    assign tx_out_valid = (tx_cnt != CNT_RST) && tx_settled;
    assign tx_out_data  = tx_bus.rdata;

    // Handshake flags, bus drive and send-now handling
    always_comb
    begin
        next_rxf_n         = !mode_active || (next_rx_cnt == CNT_RST);
        next_txe_n         = !mode_active || (next_tx_cnt == CNT_FULL);
        next_data_oe_n     = !(mode_active && !oe_n);
        next_resume        = send_now_wakeup_n_fall && pwr_n && remote_wakeup_en;
        next_flush         = flush_pending && bulk_in_req;
        next_flush_pending = flush_pending;
        if (next_flush)
        begin
            next_flush_pending = 1'b0;
        end
        if (send_now_wakeup_n_fall && !pwr_n)
        begin
            next_flush_pending = 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            rxf_n         <= 1'b1;
            txe_n         <= 1'b1;
            data_oe_n     <= 1'b1;
            pwr_n         <= 1'b1;
            resume_q      <= 1'b0;
            flush_pending <= 1'b0;
            flush_q       <= 1'b0;
        end
        else
        begin
            rxf_n         <= next_rxf_n;
            txe_n         <= next_txe_n;
            data_oe_n     <= next_data_oe_n;
            pwr_n         <= usb_suspended;
            resume_q      <= next_resume;
            flush_pending <= next_flush_pending;
            flush_q       <= next_flush;
        end
    end

    assign rx_data_avail_n  = rxf_n;
    assign tx_space_avail_n = txe_n;
    assign port_a_data_oe_n = data_oe_n;
    assign port_a_data_out  = rx_bus.rdata;
    assign power_enable_n   = pwr_n;
    assign resume_request   = resume_q;
    assign tx_flush         = flush_q;

endmodule

//--- verif/sfhp_port_props.sv
/* Assertions on the FIFO host port, bound to sfhp_port.
   Assumes one clk_sys domain with a synchronous active-high reset. */
`timescale 1ns/100ps

module sfhp_port_props
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic cfg_fifo_personality,
    input wire logic bitmode_sync_req,
    input wire logic bitmode_exit_req,
    input wire logic remote_wakeup_en,
    input wire logic mode_active,
    input wire logic channel_b_disabled,
    input wire logic interface_clock_out,
    input wire logic rx_data_avail_n,
    input wire logic tx_space_avail_n,
    input wire logic output_enable_n,
    input wire logic port_a_data_oe_n,
    input wire logic send_now_wakeup_n,
    input wire logic power_enable_n,
    input wire logic resume_request,
    input wire logic bulk_in_req,
    input wire logic tx_flush
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    sequence high_run;
        interface_clock_out [*4];
    endsequence
    sequence low_run;
        !interface_clock_out [*4];
    endsequence

    mode_entry_a: assert property (
        cfg_fifo_personality && bitmode_sync_req && !bitmode_exit_req |=> mode_active)
        else $error("mode not entered");
    mode_refused_a: assert property (
        !mode_active && !cfg_fifo_personality |=> !mode_active)
        else $error("mode entered without personality");
    chan_b_off_a: assert property (
        channel_b_disabled == mode_active)
        else $error("channel b state wrong");
    link_period_a: assert property (
        $rose(interface_clock_out) && mode_active |->
        (high_run ##1 low_run ##1 interface_clock_out) or (1'b1 ##[1:9] !mode_active))
        else $error("link clock period wrong");
    link_idle_a: assert property (
        !mode_active [*2] |-> !interface_clock_out)
        else $error("link clock runs with mode off");
    bus_release_a: assert property (
        output_enable_n [*5] |-> port_a_data_oe_n)
        else $error("bus driven without enable");
    bus_drive_a: assert property (
        (mode_active && !output_enable_n) [*5] |-> !port_a_data_oe_n)
        else $error("bus not driven with enable");
    flags_off_a: assert property (
        !mode_active [*2] |-> rx_data_avail_n && tx_space_avail_n)
        else $error("flags low with mode off");
    resume_req_a: assert property (
        $fell(send_now_wakeup_n) && power_enable_n && remote_wakeup_en |-> ##[1:5] resume_request)
        else $error("no resume request");
    resume_cause_a: assert property (
        resume_request |-> power_enable_n && remote_wakeup_en && !$past(resume_request))
        else $error("resume request without cause");
    flush_cause_a: assert property (
        tx_flush |-> $past(bulk_in_req) && !power_enable_n)
        else $error("flush without bulk-in");
endmodule

bind sfhp_port sfhp_port_props props_i
(
    .clk_sys, .reset, .cfg_fifo_personality, .bitmode_sync_req, .bitmode_exit_req,
    .remote_wakeup_en, .mode_active, .channel_b_disabled, .interface_clock_out,
    .rx_data_avail_n, .tx_space_avail_n, .output_enable_n, .port_a_data_oe_n,
    .send_now_wakeup_n, .power_enable_n, .resume_request, .bulk_in_req, .tx_flush
);

//--- verif/sfhp_ctrl_model.sv
/* Far-side FIFO master: reads or writes until cnt reaches lim.
   Assumes the bench sets direction and limit between bursts. */
`timescale 1ns/100ps

module sfhp_ctrl_model
    import sfhp_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              ifclk,
    input  wire logic              rxf_n,
    input  wire logic              txe_n,
    input  wire logic [DATA_W-1:0] dout,
    input  wire logic              doe_n,
    input  wire logic              rd_en,
    input  wire logic [15:0]       lim,
    output logic                   rd_n,
    output logic                   wr_n,
    output logic                   oe_n,
    output logic      [DATA_W-1:0] din,
    output logic                   got,
    output logic      [DATA_W-1:0] got_byte,
    output logic      [15:0]       cnt
);
    logic              ck_q, rxf_q, txe_q, more;
    logic [DATA_W-1:0] d_q, wd;

    // Released bus shows the write byte wd, or its inverse while oe_n is low
    assign din  = !doe_n ? dout : (oe_n ? wd : ~wd);
    assign more = cnt < lim;

    initial
    begin
        {rd_n, wr_n, oe_n, got, ck_q} = 5'h1c;
        wd  = 8'h40;
        cnt = 16'h0000;
    end

    always @(posedge clk_sys)
    begin
        ck_q  <= ifclk;
        rxf_q <= rxf_n;
        txe_q <= txe_n;
        d_q   <= din;
        got   <= 1'b0;
        // Count transfers at the rising link edge
        if (ifclk && !ck_q)
        begin
            got      <= !rd_n && !rxf_q;
            got_byte <= d_q;
            cnt      <= cnt + 16'((!rd_n && !rxf_q) || (!wr_n && !txe_q));
            if (!wr_n && !txe_q)
                wd <= wd + 8'h01;
        end
        // Move strobes at the falling link edge
        if (!ifclk && ck_q)
        begin
            oe_n <= !(rd_en && more);
            rd_n <= !(rd_en && more && !oe_n && !rxf_n);
            wr_n <= !(!rd_en && more && oe_n && !txe_n);
        end
    end
endmodule

//--- verif/sfhp_port_tb.sv
/* Self-checking bench for sfhp_port with a far-side controller model.
   Assumes the bench plays the USB engine side itself. */
`timescale 1ns/100ps

module sfhp_port_tb
    import sfhp_pkg::*;
;
    typedef struct packed { logic rd; logic [7:0] n; logic full; } sfhp_row_s;

    logic              clk_sys, reset, cfg_fifo_personality, bitmode_sync_req;
    logic              bitmode_exit_req, usb_suspended, remote_wakeup_en, send_now_wakeup_n;
    logic              bulk_in_req, rx_in_valid, tx_out_ready, rd_strobe_n, wr_strobe_n;
    logic              output_enable_n, mode_active, channel_b_disabled, interface_clock_out;
    logic              rx_data_avail_n, tx_space_avail_n, port_a_data_oe_n, power_enable_n;
    logic              resume_request, tx_flush, rx_in_ready, tx_out_valid, rd_en, got;
    logic [DATA_W-1:0] port_a_data_in, port_a_data_out, rx_in_data, tx_out_data, got_byte;
    logic [7:0]        rx_tot = 8'ha0, rx_exp = 8'ha0, wr_exp = 8'h40;
    logic [15:0]       lim, cnt, tgt;
    int                errors = 0, cmp_count = 0, res_cnt = 0, fl_cnt = 0;
    time               t0;
    sfhp_row_s         rows [5];

    sfhp_port uut
    (
        .clk_sys, .reset, .cfg_fifo_personality, .bitmode_sync_req, .bitmode_exit_req,
        .usb_suspended, .remote_wakeup_en, .mode_active, .channel_b_disabled,
        .interface_clock_out, .rx_data_avail_n, .tx_space_avail_n, .rd_strobe_n,
        .wr_strobe_n, .output_enable_n, .port_a_data_in, .port_a_data_out,
        .port_a_data_oe_n, .send_now_wakeup_n, .power_enable_n, .resume_request,
        .bulk_in_req, .tx_flush, .rx_in_valid, .rx_in_data, .rx_in_ready,
        .tx_out_valid, .tx_out_data, .tx_out_ready
    );

    sfhp_ctrl_model far
    (
        .clk_sys(clk_sys), .ifclk(interface_clock_out), .rxf_n(rx_data_avail_n),
        .txe_n(tx_space_avail_n), .dout(port_a_data_out), .doe_n(port_a_data_oe_n),
        .rd_en(rd_en), .lim(lim), .rd_n(rd_strobe_n), .wr_n(wr_strobe_n),
        .oe_n(output_enable_n), .din(port_a_data_in), .got(got), .got_byte(got_byte),
        .cnt(cnt)
    );

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic push_rx(input int n);
        repeat (n)
        begin
            rx_in_valid <= 1'b1;
            rx_in_data  <= rx_tot;
            do @(posedge clk_sys); while (rx_in_ready !== 1'b1);
            rx_tot++;
        end
        rx_in_valid <= 1'b0;
    endtask

    task automatic pop_tx(input int n);
        tx_out_ready <= 1'b1;
        repeat (n)
        begin
            do @(posedge clk_sys); while (tx_out_valid !== 1'b1);
            chk("tx_byte", 16'(wr_exp), 16'(tx_out_data));
            wr_exp++;
        end
        tx_out_ready <= 1'b0;
    endtask

    task automatic wake_pulse();
        send_now_wakeup_n <= 1'b0;
        cyc(8);
        send_now_wakeup_n <= 1'b1;
        cyc(8);
    endtask

    task automatic bulk_pulse();
        bulk_in_req <= 1'b1;
        cyc(1);
        bulk_in_req <= 1'b0;
        cyc(3);
    endtask

    task automatic end_sim();
        if (errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        if (got === 1'b1)
        begin
            chk("read_byte", 16'(rx_exp), 16'(got_byte));
            rx_exp++;
        end
        if (resume_request === 1'b1)
            res_cnt++;
        if (tx_flush === 1'b1)
            fl_cnt++;
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        end_sim();
    end

    initial
    begin
        rows = '{'{1'b1, 8'h01, 1'b0}, '{1'b1, 8'h05, 1'b0}, '{1'b0, 8'h03, 1'b0},
                 '{1'b0, 8'h10, 1'b1}, '{1'b1, 8'h10, 1'b1}};
        {cfg_fifo_personality, bitmode_sync_req, bitmode_exit_req, remote_wakeup_en} = 4'h0;
        {send_now_wakeup_n, usb_suspended, reset} = 3'h7;
        {bulk_in_req, rx_in_valid, tx_out_ready, rd_en} = 4'h0;
        rx_in_data = 8'h00;
        lim = 16'h0000;
        cyc(5);
        reset <= 1'b0;
        cyc(2);
        chk("reset_state", 16'h0007, 16'({interface_clock_out, mode_active, rx_data_avail_n,
            tx_space_avail_n, port_a_data_oe_n}));
        bitmode_sync_req <= 1'b1;
        cyc(1);
        bitmode_sync_req <= 1'b0;
        cfg_fifo_personality <= 1'b1;
        usb_suspended <= 1'b0;
        cyc(3);
        chk("mode_refused", 16'h0000, 16'(mode_active));
        bitmode_sync_req <= 1'b1;
        cyc(1);
        bitmode_sync_req <= 1'b0;
        cyc(2);
        chk("mode_on", 16'h0003, 16'({mode_active, channel_b_disabled}));
        @(posedge interface_clock_out);
        t0 = $time;
        @(posedge interface_clock_out);
        chk("link_period", 16'h0320, 16'($time - t0));
        for (int r = 0; r < 5; r++)
        begin
            if (rows[r].rd)
            begin
                push_rx(int'(rows[r].n));
                cyc(3);
                chk("rx_state", 16'({!rows[r].full, 1'b0}), 16'({rx_in_ready,
                    rx_data_avail_n}));
            end
            tgt = cnt + 16'(rows[r].n);
            rd_en <= rows[r].rd;
            lim <= tgt;
            for (int k = 0; k < 400 && cnt != tgt; k++)
                cyc(1);
            chk("xfer_count", tgt, cnt);
            cyc(4);
            if (rows[r].rd)
                chk("rx_empty", 16'h0001, 16'(rx_data_avail_n));
            else
            begin
                chk("tx_full", 16'(rows[r].full), 16'(tx_space_avail_n));
                pop_tx(int'(rows[r].n));
            end
        end
        bulk_pulse();
        chk("flush_idle", 16'h0000, 16'(fl_cnt));
        wake_pulse();
        chk("flush_early", 16'h0000, 16'(fl_cnt));
        bulk_pulse();
        bulk_pulse();
        chk("flush_once", 16'h0001, 16'(fl_cnt));
        usb_suspended <= 1'b1;
        remote_wakeup_en <= 1'b1;
        cyc(2);
        wake_pulse();
        remote_wakeup_en <= 1'b0;
        cyc(2);
        wake_pulse();
        chk("resume", 16'h0001, 16'(res_cnt));
        bitmode_exit_req <= 1'b1;
        cyc(1);
        bitmode_exit_req <= 1'b0;
        cyc(3);
        chk("mode_off", 16'h0003, 16'({interface_clock_out, mode_active, rx_data_avail_n,
            tx_space_avail_n}));
        bitmode_sync_req <= 1'b1;
        cyc(1);
        bitmode_sync_req <= 1'b0;
        cyc(2);
        chk("mode_again", 16'h0001, 16'(mode_active));
        cfg_fifo_personality <= 1'b0;
        cyc(3);
        chk("mode_dropped", 16'h0000, 16'(mode_active));
        usb_suspended <= 1'b0;
        cyc(2);
        wake_pulse();
        reset <= 1'b1;
        cyc(2);
        chk("reset_flags", 16'h003c, 16'({interface_clock_out, mode_active, rx_data_avail_n,
            tx_space_avail_n, port_a_data_oe_n, power_enable_n, resume_request,
            tx_flush}));
        chk("reset_data", 16'h0000, 16'(port_a_data_out));
        reset <= 1'b0;
        cyc(2);
        chk("power_follow", 16'h0000, 16'(power_enable_n));
        bulk_pulse();
        chk("flush_reset", 16'h0001, 16'(fl_cnt));
        end_sim();
    end
endmodule
